// ===== core/rsz_pkg.sv
package rsz_pkg;

	// register offsets (byte addresses)
	localparam logic [11:0] RSZ_OFF_IN_BASE   = 12'h000;
	localparam logic [11:0] RSZ_OFF_IN_PITCH  = 12'h004;
	localparam logic [11:0] RSZ_OFF_OUT_BASE  = 12'h008;
	localparam logic [11:0] RSZ_OFF_OUT_PITCH = 12'h00C;
	localparam logic [11:0] RSZ_OFF_STATUS    = 12'h010;
	localparam logic [11:0] RSZ_OFF_HCOEF     = 12'h040;
	localparam logic [11:0] RSZ_OFF_VCOEF     = 12'h080;

	// stored bits of each programmed register
	localparam logic [31:0] RSZ_IN_BASE_WMASK   = 32'hFFFF_FFE0;
	localparam logic [31:0] RSZ_IN_PITCH_WMASK  = 32'h0000_FFE0;
	localparam logic [31:0] RSZ_OUT_BASE_WMASK  = 32'hFFFF_FFFF;
	localparam logic [31:0] RSZ_OUT_PITCH_WMASK = 32'h0000_FFFF;
	// bits the memory engines may see
	localparam logic [31:0] RSZ_ALIGN_MASK      = 32'hFFFF_FFE0;
	localparam logic [31:0] RSZ_REG_RST         = 32'h0000_0000;

	// coefficient layout, signed 10-bit with 8 fraction bits
	localparam int          RSZ_COEF_W     = 10;
	localparam int          RSZ_ODD_LSB    = 16;
	localparam int          RSZ_EVEN_LSB   = 0;
	localparam logic [31:0] RSZ_COEF_MASK  = 32'h03FF_03FF;
	localparam logic [9:0]  RSZ_COEF_UNITY = 10'h100;

	// status fields
	localparam int RSZ_ST_BUSY_BIT = 0;
	localparam int RSZ_ST_PEND_BIT = 1;
	localparam int RSZ_ST_FCNT_LSB = 16;
	localparam int RSZ_FCNT_W      = 16;

	localparam logic [1:0] RSZ_RESP_OKAY = 2'h0;

	typedef enum logic [0:0] {
		RSZ_WAIT = 1'b0,
		RSZ_RESP = 1'b1
	} rsz_apb_e;

	typedef struct packed {
		logic [31:0] in_base;
		logic [31:0] in_pitch;
		logic [31:0] out_base;
		logic [31:0] out_pitch;
	} rsz_frame_cfg_s;

	typedef struct packed {
		logic signed [RSZ_COEF_W-1:0] odd_tap_coefficient;
		logic signed [RSZ_COEF_W-1:0] even_tap_coefficient;
	} rsz_tap_pair_s;

endpackage

// ===== core/rsz_shadow_reg.sv
`timescale 1ns/1ps
`default_nettype none

// programmed value plus the working copy used by the current frame
module rsz_shadow_reg
	import rsz_pkg::*;
#(
	parameter logic [31:0] WR_MASK  = 32'hFFFF_FFFF,
	parameter logic [31:0] USE_MASK = 32'hFFFF_FFFF
) (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        srst,
	// software side
	input  wire logic        wr_en,
	input  wire logic [31:0] wr_data,
	output logic      [31:0] prog_q,
	// engine side
	input  wire logic        load,
	output logic      [31:0] work_q
);

	logic [31:0] prog_r;
	logic [31:0] prog_nxt;
	logic [31:0] work_r;
	logic [31:0] work_nxt;

	always_comb begin
		prog_nxt = prog_r;
		work_nxt = work_r;
		if (wr_en) begin
			prog_nxt = wr_data & WR_MASK; // R01 R03 R06
		end
		if (load) begin
			work_nxt = prog_r & USE_MASK; // R04 R05 R07 R11
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			prog_r <= RSZ_REG_RST;
			work_r <= RSZ_REG_RST;
		end else begin
			prog_r <= prog_nxt;
			work_r <= work_nxt;
		end
	end

	assign prog_q = prog_r; // R08
	assign work_q = work_r;

endmodule

`default_nettype wire

// ===== core/rsz_addr_coef_regs.sv
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// R01: input base address is 32 bits; low five bits read zero, writes ignored.
// R02: software writes zero base and pitch when input is not from memory.
// R03: input pitch is bits 15..0; low five bits read-only zero.
// R04: output base low five bits are used as zero by the engines.
// R05: output pitch bits 15..0, upper half reserved, low five bits used as zero.
// R06: address and pitch registers accept writes at any time, even busy.
// R07: values written mid-frame take effect only at the next frame start.
// R08: reads return the most recent written value, not the working one.
// R09: coefficient words hold odd tap 25..16, even tap 9..0, rest zero.
// R10: coefficients are signed 10-bit, eight fraction bits; unity is 100h.
// R11: working copies load from programmed values at each frame start.
module rsz_addr_coef_regs
	import rsz_pkg::*;
#(
	parameter int HC_NUM = 16,
	parameter int VC_NUM = 16,
	parameter int HPW    = $clog2(HC_NUM),
	parameter int VPW    = $clog2(VC_NUM)
) (
	// clock and reset
	input  wire logic             sys_clk,
	input  wire logic             srst,
	// apb slave
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire logic [31:0]      pwdata,
	input  wire logic [3:0]       pstrb,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	// resizer core
	input  wire logic             busy,
	input  wire logic             frame_start,
	output rsz_frame_cfg_s        frame_cfg,
	// coefficient lookup
	input  wire logic [HPW-1:0]   hcoef_phase,
	input  wire logic [VPW-1:0]   vcoef_phase,
	output rsz_tap_pair_s         hcoef_pair,
	output rsz_tap_pair_s         vcoef_pair
);

	localparam logic [9:0] HB_W = RSZ_OFF_HCOEF[11:2];
	localparam logic [9:0] HE_W = 10'(HB_W + 10'(HC_NUM));
	localparam logic [9:0] VB_W = RSZ_OFF_VCOEF[11:2];
	localparam logic [9:0] VE_W = 10'(VB_W + 10'(VC_NUM));

	function automatic logic [31:0] merge_strb(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  strb
	);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return res;
	endfunction

	function automatic rsz_tap_pair_s split_pair(input logic [31:0] w);
		rsz_tap_pair_s p;
		p.odd_tap_coefficient  = w[RSZ_ODD_LSB +: RSZ_COEF_W]; // R09 R10
		p.even_tap_coefficient = w[RSZ_EVEN_LSB +: RSZ_COEF_W]; // R09 R10
		return p;
	endfunction

	// apb handshake state
	rsz_apb_e    state_r;
	rsz_apb_e    state_nxt;
	logic        pready_r;
	logic        pready_nxt;
	logic        pslverr_r;
	logic        pslverr_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;

	// decode
	logic           acc;
	logic           wr;
	logic [9:0]     widx;
	logic           h_hit;
	logic           v_hit;
	logic [HPW-1:0] h_idx;
	logic [VPW-1:0] v_idx;
	logic           mapped;
	logic [3:0]     sh_we;

	// programmed and working values
	logic [31:0] prog_q [4];
	logic [31:0] work_q [4];

	// coefficient store
	logic [31:0] hcoef_mem [HC_NUM];
	logic [31:0] vcoef_mem [VC_NUM];
	logic        h_we;
	logic        v_we;
	logic [31:0] h_wdata;
	logic [31:0] v_wdata;

	// lookup and status
	rsz_tap_pair_s         hpair_r;
	rsz_tap_pair_s         hpair_nxt;
	rsz_tap_pair_s         vpair_r;
	rsz_tap_pair_s         vpair_nxt;
	logic                  busy_r;
	logic                  busy_nxt;
	logic                  pend_r;
	logic                  pend_nxt;
	logic [RSZ_FCNT_W-1:0] fcnt_r;
	logic [RSZ_FCNT_W-1:0] fcnt_nxt;
	logic [31:0]           status_w;

	always_comb begin
		acc    = psel && penable && (state_r == RSZ_WAIT);
		wr     = acc && pwrite;
		widx   = paddr[11:2];
		h_hit  = (widx >= HB_W) && (widx < HE_W);
		v_hit  = (widx >= VB_W) && (widx < VE_W);
		h_idx  = HPW'(widx - HB_W);
		v_idx  = VPW'(widx - VB_W);
		sh_we  = 4'h0;
		mapped = h_hit || v_hit;
		case (paddr)
			RSZ_OFF_IN_BASE: begin
				sh_we[0] = wr; // R06
				mapped   = 1'b1;
			end
			RSZ_OFF_IN_PITCH: begin
				sh_we[1] = wr; // R06
				mapped   = 1'b1;
			end
			RSZ_OFF_OUT_BASE: begin
				sh_we[2] = wr; // R06
				mapped   = 1'b1;
			end
			RSZ_OFF_OUT_PITCH: begin
				sh_we[3] = wr; // R06
				mapped   = 1'b1;
			end
			RSZ_OFF_STATUS: begin
				mapped = 1'b1;
			end
			default: begin
			end
		endcase
		if (paddr[1:0] != 2'h0) begin
			mapped = 1'b0;
			sh_we  = 4'h0;
		end
	end

	// address and pitch pairs
	rsz_shadow_reg #(
		.WR_MASK  (RSZ_IN_BASE_WMASK),
		.USE_MASK (RSZ_ALIGN_MASK)
	) u_in_base (
		.sys_clk (sys_clk),
		.srst    (srst),
		.wr_en   (sh_we[0]),
		.wr_data (merge_strb(prog_q[0], pwdata, pstrb)),
		.prog_q  (prog_q[0]),
		.load    (frame_start),
		.work_q  (work_q[0])
	);

	rsz_shadow_reg #(
		.WR_MASK  (RSZ_IN_PITCH_WMASK),
		.USE_MASK (RSZ_ALIGN_MASK)
	) u_in_pitch (
		.sys_clk (sys_clk),
		.srst    (srst),
		.wr_en   (sh_we[1]),
		.wr_data (merge_strb(prog_q[1], pwdata, pstrb)),
		.prog_q  (prog_q[1]),
		.load    (frame_start),
		.work_q  (work_q[1])
	);

	rsz_shadow_reg #(
		.WR_MASK  (RSZ_OUT_BASE_WMASK),
		.USE_MASK (RSZ_ALIGN_MASK)
	) u_out_base (
		.sys_clk (sys_clk),
		.srst    (srst),
		.wr_en   (sh_we[2]),
		.wr_data (merge_strb(prog_q[2], pwdata, pstrb)),
		.prog_q  (prog_q[2]),
		.load    (frame_start),
		.work_q  (work_q[2])
	);

	rsz_shadow_reg #(
		.WR_MASK  (RSZ_OUT_PITCH_WMASK),
		.USE_MASK (RSZ_ALIGN_MASK)
	) u_out_pitch (
		.sys_clk (sys_clk),
		.srst    (srst),
		.wr_en   (sh_we[3]),
		.wr_data (merge_strb(prog_q[3], pwdata, pstrb)),
		.prog_q  (prog_q[3]),
		.load    (frame_start),
		.work_q  (work_q[3])
	);

	// R07 R11
	assign frame_cfg.in_base   = work_q[0];
	assign frame_cfg.in_pitch  = work_q[1];
	assign frame_cfg.out_base  = work_q[2];
	assign frame_cfg.out_pitch = work_q[3];

	// coefficient writes
	always_comb begin
		h_we    = wr && h_hit && (paddr[1:0] == 2'h0);
		v_we    = wr && v_hit && (paddr[1:0] == 2'h0);
		h_wdata = merge_strb(hcoef_mem[h_idx], pwdata, pstrb) & RSZ_COEF_MASK; // R09
		v_wdata = merge_strb(vcoef_mem[v_idx], pwdata, pstrb) & RSZ_COEF_MASK; // R09
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			for (int i = 0; i < HC_NUM; i++) begin
				hcoef_mem[i] <= RSZ_REG_RST;
			end
			for (int i = 0; i < VC_NUM; i++) begin
				vcoef_mem[i] <= RSZ_REG_RST;
			end
		end else begin
			if (h_we) begin
				hcoef_mem[h_idx] <= h_wdata;
			end
			if (v_we) begin
				vcoef_mem[v_idx] <= v_wdata;
			end
		end
	end

	// coefficient lookup, one cycle latency
	always_comb begin
		hpair_nxt = split_pair(hcoef_mem[hcoef_phase]); // R10
		vpair_nxt = split_pair(vcoef_mem[vcoef_phase]); // R10
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			hpair_r <= '0;
			vpair_r <= '0;
		end else begin
			hpair_r <= hpair_nxt;
			vpair_r <= vpair_nxt;
		end
	end

	assign hcoef_pair = hpair_r;
	assign vcoef_pair = vpair_r;

	// frame status
	always_comb begin
		busy_nxt = busy;
		pend_nxt = 1'b0;
		fcnt_nxt = fcnt_r;
		for (int i = 0; i < 4; i++) begin
			if ((prog_q[i] & RSZ_ALIGN_MASK) != work_q[i]) begin
				pend_nxt = 1'b1;
			end
		end
		if (frame_start) begin
			fcnt_nxt = RSZ_FCNT_W'(fcnt_r + 1'b1);
		end
		status_w                                 = 32'h0000_0000;
		status_w[RSZ_ST_BUSY_BIT]                = busy_r;
		status_w[RSZ_ST_PEND_BIT]                = pend_r;
		status_w[RSZ_ST_FCNT_LSB +: RSZ_FCNT_W] = fcnt_r;
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			busy_r <= 1'b0;
			pend_r <= 1'b0;
			fcnt_r <= '0;
		end else begin
			busy_r <= busy_nxt;
			pend_r <= pend_nxt;
			fcnt_r <= fcnt_nxt;
		end
	end

	// apb answer: one wait cycle, then pready
	always_comb begin
		state_nxt   = state_r;
		pready_nxt  = 1'b0;
		pslverr_nxt = 1'b0;
		prdata_nxt  = 32'h0000_0000;
		case (state_r)
			RSZ_WAIT: begin
				if (acc) begin
					state_nxt   = RSZ_RESP;
					pready_nxt  = 1'b1;
					pslverr_nxt = !mapped;
					if (!pwrite && mapped) begin
						if (h_hit) begin
							prdata_nxt = hcoef_mem[h_idx]; // R09
						end else if (v_hit) begin
							prdata_nxt = vcoef_mem[v_idx]; // R09
						end else begin
							case (paddr)
								RSZ_OFF_IN_BASE:   prdata_nxt = prog_q[0]; // R08 R01
								RSZ_OFF_IN_PITCH:  prdata_nxt = prog_q[1]; // R08 R03
								RSZ_OFF_OUT_BASE:  prdata_nxt = prog_q[2]; // R08
								RSZ_OFF_OUT_PITCH: prdata_nxt = prog_q[3]; // R08 R05
								RSZ_OFF_STATUS:    prdata_nxt = status_w;
								default:           prdata_nxt = 32'h0000_0000;
							endcase
						end
					end
				end
			end
			RSZ_RESP: begin
				state_nxt = RSZ_WAIT;
			end
			default: begin
				state_nxt = RSZ_WAIT;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state_r   <= RSZ_WAIT;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0000_0000;
		end else begin
			state_r   <= state_nxt;
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			prdata_r  <= prdata_nxt;
		end
	end

	assign pready  = pready_r;
	assign pslverr = pslverr_r;
	assign prdata  = prdata_r;

endmodule

`default_nettype wire

// ===== bench/rsz_addr_coef_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module rsz_addr_coef_regs_assertions
	import rsz_pkg::*;
#(
	parameter int HC_NUM = 16,
	parameter int VC_NUM = 16,
	parameter int HPW    = 4,
	parameter int VPW    = 4
) (
	// clock and reset
	input wire logic           sys_clk,
	input wire logic           srst,
	// apb slave
	input wire logic           psel,
	input wire logic           penable,
	input wire logic           pwrite,
	input wire logic [11:0]    paddr,
	input wire logic [31:0]    pwdata,
	input wire logic [3:0]     pstrb,
	input wire logic [31:0]    prdata,
	input wire logic           pready,
	input wire logic           pslverr,
	// resizer core
	input wire logic           busy,
	input wire logic           frame_start,
	input wire rsz_frame_cfg_s frame_cfg,
	// coefficient lookup
	input wire logic [HPW-1:0] hcoef_phase,
	input wire logic [VPW-1:0] vcoef_phase,
	input wire rsz_tap_pair_s  hcoef_pair,
	input wire rsz_tap_pair_s  vcoef_pair
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	wire logic rdd = pready && !pwrite;
	wire logic acc = psel && penable && !pready;
	chk_access_wait: assert property (acc |=> pready) else $error("access not answered");
	chk_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
	chk_in_base_low: assert property (rdd && paddr == RSZ_OFF_IN_BASE |-> prdata[4:0] == 5'h00)
		else $error("input base low bits set");
	chk_in_pitch_bits: assert property (rdd && paddr == RSZ_OFF_IN_PITCH |-> (prdata & 32'hFFFF_001F) == 32'h0)
		else $error("input pitch fixed bits set");
	chk_coef_rsvd: assert property (rdd && paddr[11:6] inside {6'h01, 6'h02} |-> (prdata & 32'hFC00_FC00) == 32'h0)
		else $error("coefficient reserved bits set");
	chk_cfg_hold: assert property (!frame_start |=> $stable(frame_cfg))
		else $error("working copy moved mid frame");
	chk_cfg_align: assert property ((frame_cfg & {4{32'h0000_001F}}) == 128'h0)
		else $error("working copy not aligned");
	chk_out_pitch_rsvd: assert property (frame_cfg.out_pitch[31:16] == 16'h0000)
		else $error("output pitch upper half set");
	chk_busy_write: assert property (acc && busy && paddr[11:4] == 8'h00 && paddr[1:0] == 2'h0 |=> !pslverr)
		else $error("busy write refused");
	chk_misaligned: assert property (acc && paddr[1:0] != 2'h0 |=> pslverr) else $error("misaligned not refused");
	cov_busy_frame: cover property (frame_start && busy);
	cov_refused: cover property (pslverr);
	cov_coef_read: cover property (rdd && paddr[7:6] != 2'h0);
endmodule
bind rsz_addr_coef_regs rsz_addr_coef_regs_assertions #(.HC_NUM(HC_NUM), .VC_NUM(VC_NUM), .HPW(HPW), .VPW(VPW)) u_chk (
	.sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy),
	.frame_start(frame_start), .frame_cfg(frame_cfg), .hcoef_phase(hcoef_phase),
	.vcoef_phase(vcoef_phase), .hcoef_pair(hcoef_pair), .vcoef_pair(vcoef_pair)
);
`default_nettype wire

// ===== bench/tb_rsz_addr_coef_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_rsz_addr_coef_regs;
	import rsz_pkg::*;
	logic           sys_clk, srst, psel, penable, pwrite, busy, frame_start, pready, pslverr, er;
	logic [11:0]    paddr, a;
	logic [31:0]    pwdata, prdata, rd;
	logic [3:0]     pstrb, hcoef_phase, vcoef_phase;
	rsz_frame_cfg_s frame_cfg;
	rsz_tap_pair_s  hcoef_pair, vcoef_pair;
	int             miscompares = 0;
	int             tests_run = 0;
	logic [11:0]    offs [4] = '{RSZ_OFF_IN_BASE, RSZ_OFF_IN_PITCH, RSZ_OFF_OUT_BASE, RSZ_OFF_OUT_PITCH};
	logic [31:0]    msk [4] = '{RSZ_IN_BASE_WMASK, RSZ_IN_PITCH_WMASK, RSZ_OUT_BASE_WMASK, RSZ_OUT_PITCH_WMASK};

	rsz_addr_coef_regs uut (
		.sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy),
		.frame_start(frame_start), .frame_cfg(frame_cfg), .hcoef_phase(hcoef_phase),
		.vcoef_phase(vcoef_phase), .hcoef_pair(hcoef_pair), .vcoef_pair(vcoef_pair)
	);

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task print_verdict;
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			miscompares++;
			print_verdict;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	task rdc(input logic [11:0] ad, input logic [31:0] exp);
		apb(1'b0, ad, 32'h0);
		chk(rd, exp);
	endtask

	task fs;
		frame_start <= 1'b1;
		@(posedge sys_clk);
		frame_start <= 1'b0;
		@(posedge sys_clk);
	endtask

	initial begin
		srst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hF;
		busy = 1'b0;
		frame_start = 1'b0;
		hcoef_phase = 4'h0;
		vcoef_phase = 4'h0;
		repeat (4) @(posedge sys_clk);
		srst <= 1'b0;
		rdc(RSZ_OFF_IN_PITCH, RSZ_REG_RST);
		rdc(RSZ_OFF_VCOEF, RSZ_REG_RST);
		busy <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, offs[i], 32'hFFFF_FFFF);
			rdc(offs[i], msk[i]);
		end
		chk(frame_cfg.in_base, 32'h0);
		fs;
		chk(frame_cfg.in_base, 32'hFFFF_FFE0);
		chk(frame_cfg.in_pitch, 32'h0000_FFE0);
		chk(frame_cfg.out_base, 32'hFFFF_FFE0);
		chk(frame_cfg.out_pitch, 32'h0000_FFE0);
		pstrb <= 4'h1;
		apb(1'b1, RSZ_OFF_OUT_BASE, 32'h0);
		pstrb <= 4'hF;
		rdc(RSZ_OFF_OUT_BASE, 32'hFFFF_FF00);
		chk(frame_cfg.out_base, 32'hFFFF_FFE0);
		rdc(RSZ_OFF_STATUS, 32'h0001_0003);
		chk({31'h0, er}, 32'h0);
		fs;
		chk(frame_cfg.out_base, 32'hFFFF_FF00);
		busy <= 1'b0;
		rdc(12'h0C0, 32'h0);
		chk({31'h0, er}, 32'h1);
		apb(1'b1, 12'h002, 32'h0);
		chk({31'h0, er}, 32'h1);
		rdc(RSZ_OFF_IN_BASE, 32'hFFFF_FFE0);
		apb(1'b1, RSZ_OFF_IN_BASE, 32'h0000_0000);
		apb(1'b1, RSZ_OFF_IN_PITCH, 32'h0000_0000);
		fs;
		chk(frame_cfg.in_base, 32'h0000_0000);
		chk(frame_cfg.in_pitch, 32'h0000_0000);
		rdc(RSZ_OFF_STATUS, 32'h0003_0000);
		for (int k = 0; k < 16; k += 15) begin
			a = 12'(4 * k);
			apb(1'b1, RSZ_OFF_HCOEF + a, 32'hFFFF_FFFF);
			rdc(RSZ_OFF_HCOEF + a, RSZ_COEF_MASK);
			apb(1'b1, RSZ_OFF_VCOEF + a, {6'h00, RSZ_COEF_UNITY, 6'h00, 10'h200});
			hcoef_phase <= 4'(k);
			vcoef_phase <= 4'(k);
			repeat (2) @(posedge sys_clk);
			chk({12'h000, hcoef_pair}, 32'h000F_FFFF);
			chk({12'h000, vcoef_pair}, {12'h000, RSZ_COEF_UNITY, 10'h200});
		end
		srst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
		rdc(RSZ_OFF_OUT_BASE, RSZ_REG_RST);
		chk(frame_cfg.out_base, RSZ_REG_RST);
		rdc(RSZ_OFF_HCOEF + 12'h03C, RSZ_REG_RST);
		chk({12'h000, vcoef_pair}, 32'h0000_0000);
		rdc(RSZ_OFF_STATUS, RSZ_REG_RST);
		print_verdict;
	end
endmodule
`default_nettype wire
